/* include/swshf_consts.vh */
// Constants for the stack word shifter: operation codes, operand sizes and field positions.
// Assumes inclusion by the shifter design files only.
`ifndef SWSHF_CONSTS_VH
`define SWSHF_CONSTS_VH

`define SWSHF_OP_ARITH_SHIFT_LEFT 3'h0
`define SWSHF_OP_ARITH_SHIFT_RIGHT 3'h1
`define SWSHF_OP_LOGIC_SHIFT_LEFT 3'h2
`define SWSHF_OP_LOGIC_SHIFT_RIGHT 3'h3
`define SWSHF_OP_ROTATE_LEFT 3'h4
`define SWSHF_OP_ROTATE_RIGHT 3'h5
`define SWSHF_OP_TRIPLE_NORMALIZE_LEFT 3'h6

`define SWSHF_SIZE_SINGLE 2'h1
`define SWSHF_SIZE_DOUBLE 2'h2
`define SWSHF_SIZE_TRIPLE 2'h3

`define SWSHF_BITS_SINGLE 7'h10
`define SWSHF_BITS_DOUBLE 7'h20
`define SWSHF_BITS_TRIPLE 7'h30

`define SWSHF_SIGN_MASK 48'h800000000000
`define SWSHF_ALL_ONES 48'hFFFFFFFFFFFF
`define SWSHF_NORM_CLEAR_MASK 48'h03FFFFFFFFFF
`define SWSHF_NORM_EMPTY_COUNT 6'h2A
`define SWSHF_NORM_FIELD_BITS 42
`define SWSHF_RESET_WORD 16'h0000

`endif

/* verilog/swshf_lead_zero.v */
// Leading-zero counter for the normalizing triple shift.
// Assumes a 42-bit field holding bit 9 of the most significant word down to the last bit of the low word.
`timescale 1ns/1ps
`include "swshf_consts.vh"

module swshf_lead_zero (
	input wire [41:0] field_in,
	output reg [5:0] count_out
);
	integer i;
	reg found;
	reg [31:0] pos_from_top;

	always @* begin
		found = 1'h0;
		pos_from_top = 32'h00000000;
		count_out = `SWSHF_NORM_EMPTY_COUNT;
		for (i = `SWSHF_NORM_FIELD_BITS - 1; i >= 0; i = i - 1) begin
			if (!found && field_in[i]) begin
				found = 1'h1;
				pos_from_top = `SWSHF_NORM_FIELD_BITS - 1 - i;
				count_out = pos_from_top[5:0];
			end
		end
	end
endmodule

/* verilog/swshf_shifter.v */
// Shift unit for a 16-bit stack machine: single, double and triple word shifts plus triple normalize.
// Assumes the microprogram presents operands and a start pulse on the same clock and takes results a cycle later.
//
// Summary of operation
// - Every arithmetic shift keeps the operand's sign bit unchanged.
// - Arithmetic left shifts lose bits leaving the bit just below the sign and fill zeros from below.
// - Arithmetic right shifts fill copies of the sign from above and lose bits leaving the low end.
// - Logical shifts move all bits, sign included, lose bits off the far end and fill zeros.
// - Rotates lose no bits; what leaves one end re-enters at the other.
// - The count is the argument field, plus the index register when the indexing flag is set.
// - All shifts but the normalize use the count modulo 64, so 64 means no shift.
// - Counts at or beyond the magnitude width give zero or sign-filled magnitude, while rotates keep turning.
// - Only the normalize shift may change the index register.
// - Double word shifts treat both words as one operand, bits crossing and wrapping between them.
// - Triple word operands take the top word as least significant, the next as middle, the third as most.
// - The normalize ignores the argument and shifts left until a one sits in bit 9 of the most significant word, counting.
// - After normalizing, bits 10 through 15 of the most significant word are cleared.
// - The normalize starts the index at zero unless indexing is set, in which case it adds to the index.
// - An operand with nothing from bit 9 of the most significant word downward skips shifting and counts 42.
`timescale 1ns/1ps
`include "swshf_consts.vh"

module swshf_shifter (
	input wire clk_sys_in,
	input wire reset_in,
	input wire ce_in,
	input wire start_in,
	input wire [2:0] op_in,
	input wire [1:0] size_in,
	input wire indexed_in,
	input wire [5:0] arg_in,
	input wire [15:0] index_in,
	input wire [15:0] top_of_stack_word_in,
	input wire [15:0] second_word_in,
	input wire [15:0] third_word_in,
	output wire done_out,
	output wire [15:0] top_of_stack_word_out,
	output wire [15:0] second_word_out,
	output wire [15:0] third_word_out,
	output wire [15:0] index_out,
	output wire index_we_out
);
	wire [15:0] count_sum;
	wire [5:0] amount;
	wire [5:0] norm_count;
	reg [6:0] width_bits;
	reg [47:0] operand;
	reg [47:0] width_mask;
	reg [6:0] rot_amount;
	reg [47:0] sign_fill;
	reg [47:0] result;
	reg [15:0] norm_index;
	reg norm_write;
	reg [15:0] shaped_top;
	reg [15:0] shaped_second;
	reg [15:0] shaped_third;

	// Registered state; each register takes the next value formed by the combinational blocks below.
	reg done_ff;
	reg index_we_ff;
	reg [15:0] top_of_stack_word_ff;
	reg [15:0] second_word_ff;
	reg [15:0] third_word_ff;
	reg [15:0] index_ff;
	reg nxt_done;
	reg nxt_index_we;
	reg [15:0] nxt_top_of_stack_word;
	reg [15:0] nxt_second_word;
	reg [15:0] nxt_third_word;
	reg [15:0] nxt_index;

	// Only six bits of the sum reach the shifter, so the carry out of them is dropped on purpose.
	assign count_sum = indexed_in ? (index_in + {10'h000, arg_in}) : {10'h000, arg_in};
	assign amount = count_sum[5:0];

	// Operands are left-aligned in a 48-bit field so one shifter serves all three sizes.
	always @* begin
		case (size_in)
			`SWSHF_SIZE_SINGLE: begin
				width_bits = `SWSHF_BITS_SINGLE;
				operand = {top_of_stack_word_in, 32'h00000000};
				rot_amount = {3'h0, amount[3:0]};
			end
			`SWSHF_SIZE_DOUBLE: begin
				width_bits = `SWSHF_BITS_DOUBLE;
				operand = {second_word_in, top_of_stack_word_in, 16'h0000};
				rot_amount = {2'h0, amount[4:0]};
			end
			default: begin
				width_bits = `SWSHF_BITS_TRIPLE;
				operand = {third_word_in, second_word_in, top_of_stack_word_in};
				rot_amount = (amount >= 6'h30) ? {1'b0, amount - 6'h30} : {1'b0, amount};
			end
		endcase
		width_mask = ~(`SWSHF_ALL_ONES >> width_bits);
	end

	// The normalize searches from bit 9 of the most significant word down to the last bit of the low word.
	swshf_lead_zero u_lead_zero (
		.field_in(operand[41:0]),
		.count_out(norm_count)
	);

	always @* begin
		// The sign-extending shift has its own variable, because masking it in place would make it unsigned.
		sign_fill = $signed(operand) >>> amount;
		norm_index = index_ff;
		norm_write = 1'h0;
		case (op_in)
			`SWSHF_OP_ARITH_SHIFT_LEFT: begin
				// Shifts past the magnitude width leave only the sign, as the zero fill runs all the way up.
				result = (operand & `SWSHF_SIGN_MASK) | ((operand << amount) & ~`SWSHF_SIGN_MASK);
			end
			`SWSHF_OP_ARITH_SHIFT_RIGHT: begin
				result = sign_fill & width_mask;
			end
			`SWSHF_OP_LOGIC_SHIFT_LEFT: begin
				result = operand << amount;
			end
			`SWSHF_OP_LOGIC_SHIFT_RIGHT: begin
				result = (operand >> amount) & width_mask;
			end
			`SWSHF_OP_ROTATE_LEFT: begin
				result = ((operand << rot_amount) | (operand >> (width_bits - rot_amount))) & width_mask;
			end
			`SWSHF_OP_ROTATE_RIGHT: begin
				result = ((operand >> rot_amount) | (operand << (width_bits - rot_amount))) & width_mask;
			end
			`SWSHF_OP_TRIPLE_NORMALIZE_LEFT: begin
				// An empty field gives a count of 42, which shifts everything out: same answer as the skip.
				result = (operand << norm_count) & `SWSHF_NORM_CLEAR_MASK;
				norm_index = indexed_in ? (index_in + {10'h000, norm_count}) : {10'h000, norm_count};
				norm_write = 1'h1;
			end
			default: begin
				result = operand;
			end
		endcase
	end

	// Each word goes back where it came from; words outside the operand pass through untouched.
	always @* begin
		case (size_in)
			`SWSHF_SIZE_SINGLE: begin
				shaped_top = result[47:32];
				shaped_second = second_word_in;
				shaped_third = third_word_in;
			end
			`SWSHF_SIZE_DOUBLE: begin
				shaped_top = result[31:16];
				shaped_second = result[47:32];
				shaped_third = third_word_in;
			end
			default: begin
				shaped_top = result[15:0];
				shaped_second = result[31:16];
				shaped_third = result[47:32];
			end
		endcase
	end

	// A low enable holds every register, so a stalled microprogram keeps seeing the last answer.
	always @* begin
		nxt_done = done_ff;
		nxt_index_we = index_we_ff;
		nxt_top_of_stack_word = top_of_stack_word_ff;
		nxt_second_word = second_word_ff;
		nxt_third_word = third_word_ff;
		nxt_index = index_ff;
		if (ce_in) begin
			nxt_done = start_in;
			nxt_index_we = start_in & norm_write;
			if (start_in) begin
				nxt_top_of_stack_word = shaped_top;
				nxt_second_word = shaped_second;
				nxt_third_word = shaped_third;
				nxt_index = norm_index;
			end
		end
	end

	// The strobes live in their own process so that they never wait on the wide word datapath.
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			done_ff <= 1'h0;
			index_we_ff <= 1'h0;
		end else begin
			done_ff <= nxt_done;
			index_we_ff <= nxt_index_we;
		end
	end

	// The result words are cleared by reset so the stack never sees stale data from before it.
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			top_of_stack_word_ff <= `SWSHF_RESET_WORD;
			second_word_ff <= `SWSHF_RESET_WORD;
			third_word_ff <= `SWSHF_RESET_WORD;
		end else begin
			top_of_stack_word_ff <= nxt_top_of_stack_word;
			second_word_ff <= nxt_second_word;
			third_word_ff <= nxt_third_word;
		end
	end

	// The index register has a process of its own, since only the normalize ever loads a new value into it.
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			index_ff <= `SWSHF_RESET_WORD;
		end else begin
			index_ff <= nxt_index;
		end
	end

	// Every output is a plain copy of a register, so no decoding sits between the flip-flops and the pins.
	assign done_out = done_ff;
	assign index_we_out = index_we_ff;
	assign top_of_stack_word_out = top_of_stack_word_ff;
	assign second_word_out = second_word_ff;
	assign third_word_out = third_word_ff;
	assign index_out = index_ff;
endmodule

/* sim/swshf_properties.sv */
// Port assertions for the stack word shifter.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module swshf_properties (input wire clk_sys_in, reset_in, ce_in, start_in, indexed_in, done_out, index_we_out,
	input wire [2:0] op_in, input wire [1:0] size_in, input wire [5:0] arg_in,
	input wire [15:0] top_of_stack_word_in, top_of_stack_word_out, second_word_out, third_word_out, index_out);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	wire t = ce_in && start_in;
	wire s1 = t && size_in == 2'h1 && !indexed_in;
	wire n = t && op_in == 3'h6;
	wire [15:0] a = top_of_stack_word_in;
	wire [15:0] y = top_of_stack_word_out;
	sign_kept_a: assert property (s1 && op_in[2:1] == 2'h0 |=> y[15] == $past(a[15])) else $error("sign lost");
	asl_mag_a: assert property (s1 && op_in == 3'h0 |=> y[14:0] == $past(a[14:0] << arg_in)) else $error("asl");
	lsl_word_a: assert property (s1 && op_in == 3'h2 |=> y == $past(a << arg_in)) else $error("lsl");
	rotl_word_a: assert property (s1 && op_in == 3'h4 |=> y == $past({a, a} << arg_in[3:0] >> 16)) else $error("rol");
	index_kept_a: assert property (t && op_in != 3'h6 ##1 1 |-> $stable(index_out)) else $error("index moved");
	index_we_a: assert property (t |=> index_we_out == $past(op_in == 3'h6)) else $error("index write");
	norm_clear_a: assert property (n |=> third_word_out[15:10] == 6'h00) else $error("top bits");
	norm_lead_a: assert property (n |=> third_word_out[9] || {third_word_out, second_word_out, y} == 48'h0)
		else $error("no lead");
	cover property (n);
	cover property (s1 && op_in == 3'h5);
	cover property (t && indexed_in);
endmodule

/* sim/swshf_cpu_model.sv */
// Far-side index register of the CPU, written back from the shifter.
// Assumes the write strobe and the new index arrive in the same cycle.
`timescale 1ns/1ps
module swshf_cpu_model (input wire clk_sys_in, reset_in, index_we_in, input wire [15:0] index_new_in,
	output wire [15:0] index_out);
	reg [15:0] index_ff;
	// Forwarding lets a shift taken right after a normalize see the new count.
	assign index_out = index_we_in ? index_new_in : index_ff;
	always @(posedge clk_sys_in) begin
		if (reset_in)
			index_ff <= 16'h0000;
		else if (index_we_in)
			index_ff <= index_new_in;
	end
endmodule

/* sim/swshf_shifter_test.sv */
// Random and corner-case bench for the stack word shifter.
// Assumes the shifter answers one cycle after each taken start.
`timescale 1ns/1ps
module swshf_shifter_test;
	reg clk_sys_in = 0, reset_in = 1, ce_in = 0, start_in = 0, indexed_in = 0, exp_done = 0, exp_we = 0;
	reg [2:0] op_in = 0;
	reg [1:0] size_in = 0;
	reg [2:0] rop = 0;
	reg [5:0] arg_in = 0;
	reg [15:0] top_of_stack_word_in = 0, second_word_in = 0, third_word_in = 0, exp_x = 0;
	reg [47:0] exp_v = 0;
	wire [15:0] index_in, top_of_stack_word_out, second_word_out, third_word_out, index_out;
	wire done_out, index_we_out;
	integer n_errors = 0, check_count = 0, cycles = 0, i;
	always #10 clk_sys_in = ~clk_sys_in;
	swshf_shifter uut (.clk_sys_in, .reset_in, .ce_in, .start_in, .op_in, .size_in, .indexed_in, .arg_in, .index_in,
		.top_of_stack_word_in, .second_word_in, .third_word_in, .done_out, .top_of_stack_word_out, .second_word_out,
		.third_word_out, .index_out, .index_we_out);
	swshf_cpu_model cpu (.clk_sys_in, .reset_in, .index_we_in(index_we_out), .index_new_in(index_out), .index_out(index_in));
	// Works on the operand left-aligned in 48 bits so every size shares one shifter.
	function [63:0] ref_op(input [2:0] op, input [1:0] sz, input [5:0] amt, input [47:0] v);
		reg [47:0] l, r;
		integer w, n;
		begin
			w = (sz == 2'h1) ? 16 : (sz == 2'h2) ? 32 : 48;
			l = v << (48 - w);
			n = 0;
			case (op)
				3'h0: r = {l[47], l[46:0] << amt};
				3'h1: r = $signed(l) >>> amt;
				3'h2: r = l << amt;
				3'h3: r = l >> amt;
				3'h4: r = (l << (amt % w)) | (l >> (w - amt % w));
				3'h5: r = (l >> (amt % w)) | (l << (w - amt % w));
				3'h6: begin
					while (n < 42 && !v[41 - n]) n = n + 1;
					r = (v << n) & 48'h03FFFFFFFFFF;
				end
				default: r = l;
			endcase
			ref_op = {n[15:0], (v & ~(48'hFFFFFFFFFFFF >> (48 - w))) | (r >> (48 - w))};
		end
	endfunction
	task cmp(input string nm, input [47:0] e, input [47:0] g);
		begin
			check_count = check_count + 1;
			if (e !== g) begin
				n_errors = n_errors + 1;
				$display("[FAIL] %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task step(input s, input c, input [2:0] op, input [1:0] sz, input x, input [5:0] arg, input [47:0] v);
		reg [63:0] q;
		begin
			@(negedge clk_sys_in);
			cmp("done", exp_done, done_out);
			cmp("index_we", exp_we, index_we_out);
			cmp("words", exp_v, {third_word_out, second_word_out, top_of_stack_word_out});
			cmp("index", exp_x, index_out);
			{start_in, ce_in, op_in, size_in, indexed_in, arg_in} = {s, c, op, sz, x, arg};
			{third_word_in, second_word_in, top_of_stack_word_in} = v;
			if (c) begin
				exp_done = s;
				exp_we = s && op == 3'h6;
				q = ref_op(op, sz, arg + (x ? exp_x[5:0] : 6'h00), v);
				if (s) exp_v = q[47:0];
				if (s && op == 3'h6) exp_x = q[63:48] + (x ? exp_x : 16'h0000);
			end
		end
	endtask
	task end_sim;
		begin
			if (n_errors == 0 && check_count > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	always @(posedge clk_sys_in) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			n_errors = n_errors + 1;
			end_sim;
		end
	end
	initial begin
		i = $urandom(61859);
		repeat (8) @(posedge clk_sys_in);
		@(negedge clk_sys_in) reset_in = 0;
		step(1, 1, 3'h6, 2'h3, 0, 6'h00, 48'h0);
		step(1, 1, 3'h0, 2'h1, 1, 6'h16, 48'hFFFF0000A5A5);
		step(1, 1, 3'h6, 2'h3, 1, 6'h09, 48'h020000000001);
		step(1, 1, 3'h3, 2'h2, 0, 6'h3F, 48'h1234FFFFFFFF);
		step(1, 1, 3'h1, 2'h3, 0, 6'h32, 48'h800000000000);
		for (i = 0; i < 2000; i = i + 1) begin
			rop = $urandom % 8;
			step($urandom % 4 != 0, $urandom % 8 != 0, rop, rop == 3'h6 ? 2'h3 : $urandom % 4, $urandom % 2,
				$urandom, {$urandom, $urandom} >> ($urandom % 48));
		end
		// Idle the inputs before a mid-run reset so nothing is taken on the edge after its release.
		step(0, 1, 3'h0, 2'h1, 0, 6'h00, 48'h0);
		@(negedge clk_sys_in) reset_in = 1;
		@(negedge clk_sys_in) reset_in = 0;
		{exp_done, exp_we, exp_x, exp_v} = 0;
		step(1, 1, 3'h6, 2'h3, 1, 6'h00, 48'h000000000001);
		step(0, 1, 3'h0, 2'h1, 0, 6'h00, 48'h0);
		end_sim;
	end
endmodule
bind swshf_shifter swshf_properties chk (.clk_sys_in, .reset_in, .ce_in, .start_in, .indexed_in, .done_out,
	.index_we_out, .op_in, .size_in, .arg_in, .top_of_stack_word_in, .top_of_stack_word_out, .second_word_out,
	.third_word_out, .index_out);
